/* File: design/crtcv_defs.vh */
// register indices, field positions and reset values of the crtc slice
`ifndef CRTCV_DEFS_VH
`define CRTCV_DEFS_VH

`define CRTCV_IDX_START_HI 8'h0c
`define CRTCV_IDX_START_LO 8'h0d
`define CRTCV_IDX_CUR_HI 8'h0e
`define CRTCV_IDX_CUR_LO 8'h0f
`define CRTCV_IDX_VSS_LO 8'h10
`define CRTCV_IDX_VSE_CTL 8'h11
`define CRTCV_IDX_LAST_LO 8'h12
`define CRTCV_IDX_OVERFLOW 8'h07

`define CRTCV_REG_RESET 8'h00
`define CRTCV_VSE_RESET 8'h00
`define CRTCV_VSE_RMASK 8'hbf

`define CRTCV_VSE_PROT_BIT 7
`define CRTCV_VSE_IEN_N_BIT 5
`define CRTCV_VSE_ICLR_BIT 4
`define CRTCV_VSE_END_MSB 3

`define CRTCV_OVF_FREE_MASK 8'h10
`define CRTCV_OVF_ALL_MASK 8'hff
`define CRTCV_OVF_VSS8_BIT 2
`define CRTCV_OVF_VSS9_BIT 7
`define CRTCV_OVF_LAST8_BIT 1
`define CRTCV_OVF_LAST9_BIT 6

`define CRTCV_LINE_W 12
`define CRTCV_ADDR_W 32

`endif

/* File: design/crtcv_line_ctr.v */
// scan line counter, zero on the first active line
`timescale 1ns/1ps
module crtcv_line_ctr #(
    parameter W = 12
) (
    clk_sys,
    nrst,
    frame_start,
    line_tick,
    line
);
    input wire clk_sys;
    input wire nrst;
    input wire frame_start;
    input wire line_tick;
    output reg [W-1:0] line;

    // frame_start wins so a frame always begins on line zero
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            line <= {W{1'b0}};
        end else if (frame_start) begin
            line <= {W{1'b0}};
        end else if (line_tick) begin
            line <= line + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

/* File: design/crtcv_vsync_gen.v */
// vertical sync pulse from start line and 4-bit end field
`timescale 1ns/1ps
module crtcv_vsync_gen #(
    parameter W = 12
) (
    clk_sys,
    nrst,
    line,
    sync_start,
    sync_end,
    vsync,
    vsync_rise
);
    input wire clk_sys;
    input wire nrst;
    input wire [W-1:0] line;
    input wire [W-1:0] sync_start;
    input wire [3:0] sync_end;
    output reg vsync;
    output reg vsync_rise;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            vsync <= 1'b0;
            vsync_rise <= 1'b0;
        end else begin
            vsync_rise <= 1'b0;
            if (!vsync && line == sync_start) begin
                vsync <= 1'b1;
                vsync_rise <= 1'b1;
            end else if (vsync && line != sync_start
                         && line[3:0] == sync_end) begin
                // end equal to start low bits gives a 16-line pulse
                vsync <= 1'b0;
            end
        end
    end
endmodule

/* File: design/crtcv_regs.v */
// crtc slice: start address, cursor, vertical sync, last line, retrace flag
// Contract
// - standard mode start offset is high byte over low byte, 16 bits.
// - extended start: top, mid 5-0, high, low, two zero bits.
// - extended start loads at next vsync after request, then request clears.
// - cursor offset is cursor high byte over cursor low byte.
// - cursor location is used in text modes only, ignored in graphics.
// - standard sync start: overflow bits 7 and 2 over sync start byte.
// - extended sync start: extended upper nibble over sync start byte.
// - vsync begins on the line equal to sync start, line 0 first.
// - vsync ends when line low nibble equals the sync end field.
// - protect bit blocks writes to 00h-07h except overflow bit 4.
// - retrace interrupt raised at vsync start only while enable bit is 0.
// - no interrupt line; pending state shown as input status bit 7.
// - clear bit 0 clears pending; must return to 1 before next one.
// - standard last line: overflow bits 6 and 1 over end byte.
// - extended last line: extended upper nibble over end byte.
// - active area spans last line value plus one lines.
`timescale 1ns/1ps
`include "crtcv_defs.vh"
module crtcv_regs #(
    parameter LINE_W = `CRTCV_LINE_W
) (
    clk_sys,
    nrst,
    io_index,
    io_wr,
    io_rd,
    io_wdata,
    io_rdata,
    mode_ext,
    text_mode,
    overflow_bits,
    ext_start_mid,
    ext_start_top,
    ext_sync_upper,
    ext_active_upper,
    start_update_req,
    frame_start,
    line_tick,
    start_update_clear,
    low_wr,
    low_wr_mask,
    start_addr,
    cursor_addr,
    cursor_valid,
    vsync,
    disp_active,
    last_line,
    retrace_pending
);
    input wire clk_sys;
    input wire nrst;
    input wire [7:0] io_index;
    input wire io_wr;
    input wire io_rd;
    input wire [7:0] io_wdata;
    output reg [7:0] io_rdata;
    input wire mode_ext;
    input wire text_mode;
    input wire [7:0] overflow_bits;
    input wire [5:0] ext_start_mid;
    input wire [7:0] ext_start_top;
    input wire [3:0] ext_sync_upper;
    input wire [3:0] ext_active_upper;
    input wire start_update_req;
    input wire frame_start;
    input wire line_tick;
    output reg start_update_clear;
    output reg low_wr;
    output reg [7:0] low_wr_mask;
    output reg [`CRTCV_ADDR_W-1:0] start_addr;
    output reg [15:0] cursor_addr;
    output reg cursor_valid;
    output reg vsync;
    output reg disp_active;
    output reg [LINE_W-1:0] last_line;
    output reg retrace_pending;

    reg [7:0] start_address_high_byte;
    reg [7:0] start_address_low_byte;
    reg [7:0] cursor_location_high_byte;
    reg [7:0] cursor_location_low_byte;
    reg [7:0] vertical_sync_start_low;
    reg [7:0] vertical_sync_end_and_control;
    reg [7:0] last_active_line_low;

    reg [`CRTCV_ADDR_W-1:0] next_start;
    reg [LINE_W-1:0] next_sync_start;
    reg [LINE_W-1:0] next_last;
    reg [7:0] next_rdata;
    reg update_armed;

    wire [LINE_W-1:0] line;
    wire sync_level;
    wire sync_rise;
    wire wr_hit;
    wire protect;
    wire irq_gen_off;
    wire irq_clear_n;

    assign wr_hit = io_wr;
    assign protect =
        vertical_sync_end_and_control[`CRTCV_VSE_PROT_BIT];
    assign irq_gen_off =
        vertical_sync_end_and_control[`CRTCV_VSE_IEN_N_BIT];
    assign irq_clear_n =
        vertical_sync_end_and_control[`CRTCV_VSE_ICLR_BIT];

    // start address assembly for both modes
    always @* begin
        next_start = {`CRTCV_ADDR_W{1'b0}};
        if (mode_ext) begin
            next_start[31:24] = ext_start_top;
            next_start[23:18] = ext_start_mid;
            next_start[17:10] = start_address_high_byte;
            next_start[9:2] = start_address_low_byte;
            next_start[1:0] = 2'h0;
        end else begin
            next_start[15:8] = start_address_high_byte;
            next_start[7:0] = start_address_low_byte;
        end
    end

    // vertical sync start, 10 or 12 bits
    always @* begin
        next_sync_start = {LINE_W{1'b0}};
        next_sync_start[7:0] = vertical_sync_start_low;
        if (mode_ext) begin
            next_sync_start[11:8] = ext_sync_upper;
        end else begin
            next_sync_start[8] =
                overflow_bits[`CRTCV_OVF_VSS8_BIT];
            next_sync_start[9] =
                overflow_bits[`CRTCV_OVF_VSS9_BIT];
        end
    end

    // last active line, 10 or 12 bits
    always @* begin
        next_last = {LINE_W{1'b0}};
        next_last[7:0] = last_active_line_low;
        if (mode_ext) begin
            next_last[11:8] = ext_active_upper;
        end else begin
            next_last[8] =
                overflow_bits[`CRTCV_OVF_LAST8_BIT];
            next_last[9] =
                overflow_bits[`CRTCV_OVF_LAST9_BIT];
        end
    end

    // read mux; reserved bit 6 of the control register reads 0
    always @* begin
        case (io_index)
            `CRTCV_IDX_START_HI: begin
                next_rdata = start_address_high_byte;
            end
            `CRTCV_IDX_START_LO: begin
                next_rdata = start_address_low_byte;
            end
            `CRTCV_IDX_CUR_HI: begin
                next_rdata = cursor_location_high_byte;
            end
            `CRTCV_IDX_CUR_LO: begin
                next_rdata = cursor_location_low_byte;
            end
            `CRTCV_IDX_VSS_LO: begin
                next_rdata = vertical_sync_start_low;
            end
            `CRTCV_IDX_VSE_CTL: begin
                next_rdata = vertical_sync_end_and_control
                    & `CRTCV_VSE_RMASK;
            end
            `CRTCV_IDX_LAST_LO: begin
                next_rdata = last_active_line_low;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    crtcv_line_ctr #(
        .W(LINE_W)
    ) u_line (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .frame_start(frame_start),
        .line_tick(line_tick),
        .line(line)
    );

    crtcv_vsync_gen #(
        .W(LINE_W)
    ) u_vsync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .line(line),
        .sync_start(next_sync_start),
        .sync_end(vertical_sync_end_and_control[3:0]),
        .vsync(sync_level),
        .vsync_rise(sync_rise)
    );

    // register writes
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            start_address_high_byte <= `CRTCV_REG_RESET;
            start_address_low_byte <= `CRTCV_REG_RESET;
            cursor_location_high_byte <= `CRTCV_REG_RESET;
            cursor_location_low_byte <= `CRTCV_REG_RESET;
            vertical_sync_start_low <= `CRTCV_REG_RESET;
            vertical_sync_end_and_control <= `CRTCV_VSE_RESET;
            last_active_line_low <= `CRTCV_REG_RESET;
        end else if (wr_hit) begin
            case (io_index)
                `CRTCV_IDX_START_HI: begin
                    start_address_high_byte <= io_wdata;
                end
                `CRTCV_IDX_START_LO: begin
                    start_address_low_byte <= io_wdata;
                end
                `CRTCV_IDX_CUR_HI: begin
                    cursor_location_high_byte <= io_wdata;
                end
                `CRTCV_IDX_CUR_LO: begin
                    cursor_location_low_byte <= io_wdata;
                end
                `CRTCV_IDX_VSS_LO: begin
                    vertical_sync_start_low <= io_wdata;
                end
                `CRTCV_IDX_VSE_CTL: begin
                    vertical_sync_end_and_control <= io_wdata;
                end
                `CRTCV_IDX_LAST_LO: begin
                    last_active_line_low <= io_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // write protection for the low register group 00h-07h
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            low_wr <= 1'b0;
            low_wr_mask <= 8'h00;
        end else begin
            low_wr <= 1'b0;
            low_wr_mask <= 8'h00;
            if (wr_hit && io_index <= `CRTCV_IDX_OVERFLOW) begin
                if (!protect) begin
                    low_wr <= 1'b1;
                    low_wr_mask <= `CRTCV_OVF_ALL_MASK;
                end else if (io_index == `CRTCV_IDX_OVERFLOW) begin
                    // bit 4 stays writable under protection
                    low_wr <= 1'b1;
                    low_wr_mask <= `CRTCV_OVF_FREE_MASK;
                end
            end
        end
    end

    // start address: direct in standard mode, vsync loaded in extended
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            start_addr <= {`CRTCV_ADDR_W{1'b0}};
            start_update_clear <= 1'b0;
            update_armed <= 1'b0;
        end else begin
            start_update_clear <= 1'b0;
            if (!mode_ext) begin
                start_addr <= next_start;
                update_armed <= 1'b0;
            end else if (start_update_clear) begin
                // disarm for the clear cycle only, then re-sample the request
                update_armed <= 1'b0;
            end else if (sync_rise && update_armed) begin
                // bytes were complete when the request was set
                start_addr <= next_start;
                start_update_clear <= 1'b1;
                update_armed <= 1'b0;
            end else begin
                update_armed <= start_update_req;
            end
        end
    end

    // text cursor only meaningful in text modes
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cursor_addr <= 16'h0000;
            cursor_valid <= 1'b0;
        end else if (text_mode) begin
            cursor_addr <= {cursor_location_high_byte,
                            cursor_location_low_byte};
            cursor_valid <= 1'b1;
        end else begin
            cursor_addr <= 16'h0000;
            cursor_valid <= 1'b0;
        end
    end

    // timing outputs
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            vsync <= 1'b0;
            disp_active <= 1'b0;
            last_line <= {LINE_W{1'b0}};
        end else begin
            vsync <= sync_level;
            last_line <= next_last;
            disp_active <= (line <= next_last);
        end
    end

    // polled retrace flag, no interrupt pin
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            retrace_pending <= 1'b0;
        end else if (!irq_clear_n) begin
            retrace_pending <= 1'b0;
        end else if (sync_rise && !irq_gen_off) begin
            retrace_pending <= 1'b1;
        end
    end

    // read port
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            io_rdata <= next_rdata;
        end
    end
endmodule

/* File: test/crtcv_regs_asserts.sv */
// port-level assertions for the crtc register slice
`timescale 1ns/1ps
`include "crtcv_defs.vh"
module crtcv_regs_asserts (
    input wire clk_sys,
    input wire nrst,
    input wire [7:0] io_index,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata,
    input wire text_mode,
    input wire start_update_clear,
    input wire low_wr,
    input wire [7:0] low_wr_mask,
    input wire [15:0] cursor_addr,
    input wire vsync,
    input wire retrace_pending
);
    // shadow of the control byte as it stands after each write
    reg [7:0] ctl;
    wire low = io_wr && io_index <= 8'h07;
    wire ctl_wr = io_wr && io_index == `CRTCV_IDX_VSE_CTL;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctl <= 8'h00;
        end else if (ctl_wr) begin
            ctl <= io_wdata;
        end
    end
    sequence armed_rise_s;
        $rose(vsync) && !ctl[5] && ctl[4];
    endsequence
    unmapped_read_a: assert property (io_rd && (io_index < 8'h0c ||
        io_index > 8'h12) |=> io_rdata == 8'h00) else $error("bad read");
    low_wr_open_a: assert property (low && !ctl[7]
        |=> low_wr && low_wr_mask == 8'hff) else $error("open write lost");
    ovf_free_a: assert property (io_wr && io_index == 8'h07 && ctl[7]
        |=> low_wr && low_wr_mask == 8'h10) else $error("bit 4 blocked");
    cursor_gfx_a: assert property (!text_mode [*2]
        |-> cursor_addr == 16'h0000) else $error("cursor in graphics");
    pend_set_a: assert property (armed_rise_s
        |-> retrace_pending) else $error("retrace not flagged");
    pend_hold_a: assert property (retrace_pending && ctl[4]
        && !(ctl_wr && !io_wdata[4]) |=> retrace_pending)
        else $error("pending lost");
    pend_clear_a: assert property (!ctl[4] |=> !retrace_pending)
        else $error("pending not cleared");
    upd_vsync_a: assert property (start_update_clear
        |-> $rose(vsync)) else $error("update off vsync");
endmodule
bind crtcv_regs crtcv_regs_asserts chk_u (.clk_sys(clk_sys), .nrst(nrst),
    .io_index(io_index), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .text_mode(text_mode), .low_wr(low_wr),
    .start_update_clear(start_update_clear), .low_wr_mask(low_wr_mask),
    .cursor_addr(cursor_addr), .vsync(vsync),
    .retrace_pending(retrace_pending));

/* File: test/crtcv_monitor.sv */
// line timing source and vertical sync watcher on the display side
`timescale 1ns/1ps
module crtcv_monitor #(
    parameter LINES = 300
) (
    input wire clk_sys,
    input wire nrst,
    input wire vsync,
    output reg frame_start,
    output reg line_tick,
    output reg [11:0] line,
    output reg [11:0] rise_line,
    output reg [11:0] pulse_len
);
    reg [2:0] div;
    reg vs_d;
    wire last = line == 12'(LINES - 1);
    // eight clocks a line keeps the two-cycle sync lag inside one line
    always @(negedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div <= 3'h0;
            frame_start <= 1'b0;
            line_tick <= 1'b0;
        end else begin
            div <= div + 3'h1;
            frame_start <= div == 3'h7 && last;
            line_tick <= div == 3'h7 && !last;
        end
    end
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            line <= 12'h000;
            vs_d <= 1'b0;
            rise_line <= 12'h000;
            pulse_len <= 12'h000;
        end else begin
            vs_d <= vsync;
            if (frame_start) begin
                line <= 12'h000;
            end else if (line_tick) begin
                line <= line + 12'h001;
            end
            if (vsync && !vs_d) begin
                rise_line <= line;
            end
            if (!vsync && vs_d) begin
                pulse_len <= line - rise_line;
            end
        end
    end
endmodule

/* File: test/tb_crtcv_regs.sv */
// self-checking bench for the crtc register slice
`timescale 1ns/1ps
module tb_crtcv_regs;
    reg clk_sys, nrst, io_wr, io_rd, mode_ext, text_mode, start_update_req;
    reg [7:0] io_index, io_wdata, overflow_bits, ext_start_top, rv;
    reg [5:0] ext_start_mid;
    reg [3:0] ext_sync_upper, ext_active_upper;
    wire frame_start, line_tick, start_update_clear, low_wr, cursor_valid;
    wire vsync, disp_active, retrace_pending;
    wire [7:0] io_rdata, low_wr_mask;
    wire [31:0] start_addr;
    wire [15:0] cursor_addr;
    wire [11:0] last_line, line, rise_line, pulse_len;
    integer err_count, samples_checked, i;
    crtcv_regs dut_u (.clk_sys(clk_sys), .nrst(nrst), .io_index(io_index),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .mode_ext(mode_ext), .text_mode(text_mode), .line_tick(line_tick),
        .overflow_bits(overflow_bits), .ext_start_mid(ext_start_mid),
        .ext_start_top(ext_start_top), .ext_sync_upper(ext_sync_upper),
        .ext_active_upper(ext_active_upper), .frame_start(frame_start),
        .start_update_req(start_update_req), .low_wr(low_wr),
        .start_update_clear(start_update_clear), .low_wr_mask(low_wr_mask),
        .start_addr(start_addr), .cursor_addr(cursor_addr),
        .cursor_valid(cursor_valid), .vsync(vsync), .disp_active(disp_active),
        .last_line(last_line), .retrace_pending(retrace_pending));
    crtcv_monitor mon_u (.clk_sys(clk_sys), .nrst(nrst), .vsync(vsync),
        .frame_start(frame_start), .line_tick(line_tick), .line(line),
        .rise_line(rise_line), .pulse_len(pulse_len));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task hang(input string what);
        err_count++;
        $display("CHECK FAILED %s expected event seen timeout", what);
        final_report;
    endtask
    function [7:0] pat(input integer k);
        pat = {k[3:0], ~k[3:0]} | 8'h40;
    endfunction
    task wr(input logic [7:0] idx, d);
        @(negedge clk_sys);
        io_index = idx;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge clk_sys);
        io_wr = 1'b0;
    endtask
    task rd(input logic [7:0] idx);
        @(negedge clk_sys);
        io_index = idx;
        io_rd = 1'b1;
        @(negedge clk_sys);
        io_rd = 1'b0;
        rv = io_rdata;
    endtask
    // the two extra cycles let the monitor latch its line figures
    task wait_vs(input logic lvl);
        int n;
        n = 0;
        while (vsync !== lvl) begin
            @(negedge clk_sys);
            n++;
            if (n > 6000) hang("vsync");
        end
        repeat (2) @(negedge clk_sys);
    endtask
    task wait_line(input logic [11:0] l);
        int n;
        n = 0;
        while (line !== l) begin
            @(negedge clk_sys);
            n++;
            if (n > 6000) hang("line");
        end
        repeat (4) @(negedge clk_sys);
    endtask
    task t_regs;
        for (i = 12; i <= 18; i++) wr(i[7:0], pat(i));
        for (i = 12; i <= 18; i++) begin
            rd(i[7:0]);
            check("readback", rv, pat(i) & (i == 17 ? 8'hbf : 8'hff));
        end
        rd(8'h13);
        check("unmapped read", rv, 8'h00);
        check("start std", start_addr, {16'h0, pat(12), pat(13)});
        text_mode = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("cursor text", {cursor_valid, cursor_addr}, 17'h1e1f0);
        text_mode = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("cursor gfx", {cursor_valid, cursor_addr}, 17'h0);
        $display("done regs");
    endtask
    task t_protect;
        wr(8'h03, 8'h5a);
        check("low open", {low_wr, low_wr_mask}, 9'h1ff);
        wr(8'h11, 8'h9e);
        wr(8'h03, 8'h5a);
        check("low blocked", low_wr, 1'b0);
        wr(8'h07, 8'h5a);
        check("ovf bit 4", {low_wr, low_wr_mask}, 9'h110);
        wr(8'h11, 8'h1e);
        $display("done protect");
    endtask
    task t_std;
        wr(8'h11, 8'h07);
        overflow_bits = 8'h46;
        wr(8'h10, 8'h04);
        wr(8'h11, 8'h17);
        check("pending idle", retrace_pending, 1'b0);
        wait_vs(1'b0);
        wait_vs(1'b1);
        check("pending set", retrace_pending, 1'b1);
        check("start line std", rise_line, 12'd260);
        check("last std", last_line, 12'h36d);
        wait_vs(1'b0);
        check("pulse len", pulse_len, 12'd3);
        wr(8'h11, 8'h07);
        @(negedge clk_sys);
        check("pending clear", retrace_pending, 1'b0);
        $display("done std sync");
    endtask
    task t_ext;
        mode_ext = 1'b1;
        wr(8'h10, 8'h08);
        wr(8'h11, 8'h0b);
        wait_vs(1'b1);
        check("start line ext", rise_line, 12'd8);
        check("no set clr 0", retrace_pending, 1'b0);
        wait_vs(1'b0);
        ext_sync_upper = 4'h1;
        wr(8'h11, 8'h3b);
        wait_vs(1'b1);
        check("start line hi", rise_line, 12'd264);
        check("no set masked", retrace_pending, 1'b0);
        wait_vs(1'b0);
        $display("done ext sync");
    endtask
    task t_start;
        int n;
        wr(8'h0c, 8'h12);
        wr(8'h0d, 8'h34);
        ext_start_mid = 6'h2a;
        ext_start_top = 8'h9c;
        wr(8'h11, 8'h1b);
        start_update_req = 1'b1;
        repeat (4) @(negedge clk_sys);
        // still the last standard-mode value until the next vsync
        check("early load", start_addr, {16'h0, pat(12), pat(13)});
        n = 0;
        while (start_update_clear !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 6000) hang("update");
        end
        start_update_req = 1'b0;
        // top 9c, mid 2a, high 12, low 34, two zero bits
        check("start ext", start_addr, 32'h9ca848d0);
        check("load at vsync", vsync, 1'b1);
        repeat (2) @(negedge clk_sys);
        check("pending rearmed", retrace_pending, 1'b1);
        $display("done ext start");
    endtask
    task t_last;
        ext_active_upper = 4'h1;
        wr(8'h12, 8'h2d);
        @(negedge clk_sys);
        check("last ext", last_line, 12'h12d);
        ext_active_upper = 4'h0;
        wait_line(12'd45);
        check("last line on", disp_active, 1'b1);
        wait_line(12'd46);
        check("past last off", disp_active, 1'b0);
        $display("done last line");
    endtask
    initial begin
        err_count = 0;
        samples_checked = 0;
        {nrst, io_wr, io_rd, mode_ext, text_mode, start_update_req} = 6'h0;
        {io_index, io_wdata, overflow_bits, ext_start_top} = 32'h0;
        {ext_start_mid, ext_sync_upper, ext_active_upper} = 14'h0;
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        t_regs;
        t_protect;
        t_std;
        t_ext;
        t_start;
        t_last;
        final_report;
    end
endmodule
